// >>> ccl_pkg.sv
// Package with register map, field layout and types of the converter control bank.
package ccl_pkg;

  // ****************************************************************
  // Register offsets.
  // ****************************************************************
  localparam logic [7:0] CCL_MODE_CONTROL_ADDR = 8'h14;
  localparam logic [7:0] CCL_LIMITS_CONFIGURATION_ADDR = 8'h16;

  // ****************************************************************
  // Field positions of the mode control register.
  // ****************************************************************
  localparam int CCL_GATE_BIT = 0;
  localparam int CCL_SLEEP_BIT = 4;
  localparam int CCL_RAMP_BIT = 5;
  localparam int CCL_PULSE_HIGH_BIT = 6;
  localparam int CCL_PULSE_LOW_BIT = 7;
  localparam logic [7:0] CCL_MODE_CONTROL_MASK = 8'hF1;

  // ****************************************************************
  // Field positions of the limits configuration register.
  // ****************************************************************
  localparam int CCL_RESTART_BIT = 0;
  localparam int CCL_RSTIND_BIT = 1;
  localparam int CCL_SOFTRST_BIT = 2;
  localparam int CCL_THERM_LSB = 4;
  localparam int CCL_PEAK_LSB = 6;
  localparam logic [7:0] CCL_LIMITS_STORE_MASK = 8'hF3;

  // ****************************************************************
  // Reset values; the reset indicator comes up set.
  // ****************************************************************
  localparam logic [7:0] CCL_MODE_CONTROL_RESET = 8'h00;
  localparam logic [7:0] CCL_LIMITS_CONFIGURATION_RESET = 8'h02;

  // Warning temperatures in degrees Celsius per threshold code.
  localparam logic [7:0] CCL_WARN_TEMP_0 = 8'h53;
  localparam logic [7:0] CCL_WARN_TEMP_1 = 8'h5E;
  localparam logic [7:0] CCL_WARN_TEMP_2 = 8'h69;
  localparam logic [7:0] CCL_WARN_TEMP_3 = 8'h74;

  // Fault recovery states.
  typedef enum logic [1:0] {
    CCL_RUN = 2'b00,
    CCL_SHUTDOWN = 2'b01,
    CCL_RESTART = 2'b10
  } ccl_fault_state_t;

  // Register write request from the serial bus engine.
  typedef struct packed {
    logic wrEn;
    logic [7:0] addr;
    logic [7:0] data;
  } ccl_write_t;

  // Decoded controls to the analog core.
  typedef struct packed {
    logic selectPinGateEnable;
    logic forcedPulseMode;
    logic lowQuiescentMode;
    logic fullSleep;
    logic [1:0] peakCurrentLimit;
    logic [1:0] thermalWarningThreshold;
    logic [7:0] warnTempCelsius;
  } ccl_ctrl_t;

endpackage : ccl_pkg

// >>> ccl_regs.sv
// Converter command and limits register bank with fault restart control.
`timescale 1ns/100ps
`default_nettype none
// Function
// R01 - Gate bit D0 disables the voltage-select pin at 0, enables at 1.
// R02 - Sleep bit picks low-quiescent or full sleep when enable and select low.
// R03 - During voltage ramps, ramp bit 0 means automatic, 1 forced pulse mode.
// R04 - With mode signal high, high-state bit selects automatic or forced pulse.
// R05 - With mode signal low, low-state bit selects automatic or forced pulse.
// R06 - Mode control fields at D7, D6, D5, D4, D0; D3 to D1 read zero.
// R07 - Restart bit 0 keeps the device shut down after a thermal or short fault.
// R08 - Restart bit 1 starts a fresh power-up keeping programmed registers.
// R09 - Every reset to defaults loads the reset indicator with one.
// R10 - Host writes the reset indicator to zero to detect a later reset.
// R11 - Writing one to the soft reset bit returns all registers to defaults.
// R12 - Soft reset bit defaults to zero and clears itself, never reads one.
// R13 - Thermal threshold codes map to 83, 94, 105 and 116 degrees Celsius.
// R14 - Peak current field D7 to D6 selects one of four current limits.
// R15 - A soft reset also sets the reset indicator as part of defaults.
module ccl_regs (
  // Clock, reset and clock enable.
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clkEn,
  // Register access from the serial bus engine.
  input wire ccl_pkg::ccl_write_t regWrite,
  input wire logic [7:0] readAddr,
  output logic [7:0] readData_ff,
  // Core status inputs from the pins and protection circuits.
  input wire logic enablePin,
  input wire logic voltageSelectPin,
  input wire logic modeSignal,
  input wire logic dynamicVoltageRamp,
  input wire logic thermalShutdown,
  input wire logic outputShortFault,
  // Controls to the regulation core.
  output ccl_pkg::ccl_ctrl_t ctrl_ff,
  output logic powerStageOn_ff,
  output logic powerUpStart_ff
);
  import ccl_pkg::*;

  // ****************************************************************
  // Pin synchronisers.
  // ****************************************************************
  logic [5:0] syncA_ff;
  logic [5:0] syncB_ff;
  wire logic [5:0] rawIn = {outputShortFault, thermalShutdown,
    dynamicVoltageRamp, modeSignal, voltageSelectPin, enablePin};

  // Two flops per asynchronous input; only the second stage is used.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      syncA_ff <= 6'h00;
      syncB_ff <= 6'h00;
    end else if (clkEn) begin
      syncA_ff <= rawIn;
      syncB_ff <= syncA_ff;
    end
  end

  wire logic enS = syncB_ff[0];
  wire logic selS = syncB_ff[1];
  wire logic modeS = syncB_ff[2];
  wire logic rampS = syncB_ff[3];
  wire logic faultS = syncB_ff[4] | syncB_ff[5];

  // ****************************************************************
  // Register file.
  // ****************************************************************
  logic [7:0] modeCtrl_ff;
  logic [7:0] limits_ff;
  logic [7:0] nxt_modeCtrl;
  logic [7:0] nxt_limits;

  wire logic wrMode = regWrite.wrEn && regWrite.addr == CCL_MODE_CONTROL_ADDR;
  wire logic wrLim = regWrite.wrEn &&
    regWrite.addr == CCL_LIMITS_CONFIGURATION_ADDR;
  wire logic softReset = wrLim && regWrite.data[CCL_SOFTRST_BIT]; // see R11

  // Next register values; a soft reset loads defaults over any write.
  always_comb begin
    nxt_modeCtrl = modeCtrl_ff;
    nxt_limits = limits_ff;
    if (softReset) begin
      nxt_modeCtrl = CCL_MODE_CONTROL_RESET; // see R11
      nxt_limits = CCL_LIMITS_CONFIGURATION_RESET; // see R09 see R15
    end else begin
      if (wrMode) begin
        nxt_modeCtrl = regWrite.data & CCL_MODE_CONTROL_MASK; // see R06
      end
      if (wrLim) begin
        // Soft reset and spare bits are never stored.
        nxt_limits = regWrite.data & CCL_LIMITS_STORE_MASK; // see R12
      end
    end
  end

  // Registers load their defaults under the power-up reset.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      modeCtrl_ff <= CCL_MODE_CONTROL_RESET;
      limits_ff <= CCL_LIMITS_CONFIGURATION_RESET; // see R09
    end else if (clkEn) begin
      modeCtrl_ff <= nxt_modeCtrl;
      limits_ff <= nxt_limits;
    end
  end

  // ****************************************************************
  // Read path.
  // ****************************************************************
  wire logic [7:0] readMux =
    (readAddr == CCL_MODE_CONTROL_ADDR) ? modeCtrl_ff :
    (readAddr == CCL_LIMITS_CONFIGURATION_ADDR) ? limits_ff : 8'h00;

  // Read data is registered; unmapped addresses return zero.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      readData_ff <= 8'h00;
    end else if (clkEn) begin
      readData_ff <= readMux;
    end
  end

  // ****************************************************************
  // Operating mode decode.
  // ****************************************************************
  function automatic logic [7:0] warnTemp(input logic [1:0] code);
    case (code)
      2'b00: warnTemp = CCL_WARN_TEMP_0;
      2'b01: warnTemp = CCL_WARN_TEMP_1;
      2'b10: warnTemp = CCL_WARN_TEMP_2;
      default: warnTemp = CCL_WARN_TEMP_3;
    endcase
  endfunction : warnTemp

  // Ramp mode overrides the mode-signal selection while a ramp runs.
  wire logic stateMode = modeS ? modeCtrl_ff[CCL_PULSE_HIGH_BIT] // see R04
                               : modeCtrl_ff[CCL_PULSE_LOW_BIT]; // see R05
  wire logic pulseMode = rampS ? modeCtrl_ff[CCL_RAMP_BIT] // see R03
                               : stateMode;
  wire logic gateOn = modeCtrl_ff[CCL_GATE_BIT]; // see R01
  wire logic idleLow = !enS && !(gateOn && selS);
  wire logic sleepBit = modeCtrl_ff[CCL_SLEEP_BIT];
  ccl_ctrl_t nxt_ctrl;

  // Control word sent to the core.
  always_comb begin
    nxt_ctrl.selectPinGateEnable = gateOn;
    nxt_ctrl.forcedPulseMode = pulseMode;
    nxt_ctrl.lowQuiescentMode = idleLow && !sleepBit; // see R02
    nxt_ctrl.fullSleep = idleLow && sleepBit; // see R02
    nxt_ctrl.peakCurrentLimit = limits_ff[CCL_PEAK_LSB +: 2]; // see R14
    nxt_ctrl.thermalWarningThreshold = limits_ff[CCL_THERM_LSB +: 2];
    nxt_ctrl.warnTempCelsius = warnTemp(limits_ff[CCL_THERM_LSB +: 2]); // see R13
  end

  // Control outputs come straight from flops.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff <= '0;
    end else if (clkEn) begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // ****************************************************************
  // Fault shutdown and restart.
  // ****************************************************************
  ccl_fault_state_t state_ff;
  ccl_fault_state_t nxt_state;
  wire logic restartEn = limits_ff[CCL_RESTART_BIT];

  // A fault shuts the stage; restart only when the fault is gone and enabled.
  always_comb begin
    case (state_ff)
      CCL_RUN: nxt_state = faultS ? CCL_SHUTDOWN : CCL_RUN;
      CCL_SHUTDOWN: begin
        if (!faultS && restartEn) begin
          nxt_state = CCL_RESTART; // see R08
        end else begin
          nxt_state = CCL_SHUTDOWN; // see R07
        end
      end
      CCL_RESTART: nxt_state = faultS ? CCL_SHUTDOWN : CCL_RUN;
      default: nxt_state = CCL_SHUTDOWN;
    endcase
  end

  // State and its registered outputs; registers are not touched here.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= CCL_RUN;
      powerStageOn_ff <= 1'b0;
      powerUpStart_ff <= 1'b0;
    end else if (clkEn) begin
      state_ff <= nxt_state;
      powerStageOn_ff <= nxt_state == CCL_RUN;
      powerUpStart_ff <= nxt_state == CCL_RESTART; // see R08
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  chk_soft_reset_defaults: assert property ( // see R11
    @(posedge clock) disable iff (!rst_b)
    clkEn && softReset |=> modeCtrl_ff == CCL_MODE_CONTROL_RESET &&
      limits_ff == CCL_LIMITS_CONFIGURATION_RESET)
    else $error("Soft reset did not restore defaults.");
  chk_softrst_never_reads: assert property ( // see R12
    @(posedge clock) disable iff (!rst_b) !limits_ff[CCL_SOFTRST_BIT])
    else $error("Soft reset bit was retained.");
  chk_indicator_set: assert property ( // see R15
    @(posedge clock) disable iff (!rst_b)
    clkEn && softReset |=> limits_ff[CCL_RSTIND_BIT])
    else $error("Reset indicator not set by soft reset.");
  chk_spare_zero: assert property ( // see R06
    @(posedge clock) disable iff (!rst_b) modeCtrl_ff[3:1] == 3'b000)
    else $error("Spare mode bits not zero.");
  chk_mode_high: assert property ( // see R04
    @(posedge clock) disable iff (!rst_b)
    clkEn && modeS && !rampS |=>
      ctrl_ff.forcedPulseMode == $past(modeCtrl_ff[CCL_PULSE_HIGH_BIT]))
    else $error("High-state mode wrong.");
  chk_mode_low: assert property ( // see R05
    @(posedge clock) disable iff (!rst_b)
    clkEn && !modeS && !rampS |=>
      ctrl_ff.forcedPulseMode == $past(modeCtrl_ff[CCL_PULSE_LOW_BIT]))
    else $error("Low-state mode wrong.");
  chk_ramp_mode: assert property ( // see R03
    @(posedge clock) disable iff (!rst_b)
    clkEn && rampS |=>
      ctrl_ff.forcedPulseMode == $past(modeCtrl_ff[CCL_RAMP_BIT]))
    else $error("Ramp mode wrong.");
  chk_no_restart: assert property ( // see R07
    @(posedge clock) disable iff (!rst_b)
    clkEn && state_ff == CCL_SHUTDOWN && !restartEn |=> !powerUpStart_ff)
    else $error("Restart without enable.");
  chk_sleep_mode: assert property ( // see R02
    @(posedge clock) disable iff (!rst_b)
    clkEn && idleLow |=> ctrl_ff.fullSleep == $past(sleepBit) &&
      ctrl_ff.lowQuiescentMode == !$past(sleepBit))
    else $error("Sleep selection wrong.");

  // Write and decode checks: stored values, soft reset readback, gate, peak and warning fields.
  chk_gate_follows: assert property ( // see R01
    @(posedge clock) disable iff (!rst_b)
    clkEn |=> ctrl_ff.selectPinGateEnable ==
      $past(modeCtrl_ff[CCL_GATE_BIT]))
    else $error("Gate enable output wrong.");
  chk_mode_write: assert property ( // see R06
    @(posedge clock) disable iff (!rst_b)
    clkEn && wrMode && !softReset |=>
      modeCtrl_ff == ($past(regWrite.data) & CCL_MODE_CONTROL_MASK))
    else $error("Mode control write not stored.");
  chk_limits_write: assert property ( // see R12
    @(posedge clock) disable iff (!rst_b)
    clkEn && wrLim && !softReset |=>
      limits_ff == ($past(regWrite.data) & CCL_LIMITS_STORE_MASK))
    else $error("Limits write not stored.");
  chk_softrst_read: assert property ( // see R12
    @(posedge clock) disable iff (!rst_b) !readData_ff[CCL_SOFTRST_BIT])
    else $error("Soft reset bit was read back.");
  chk_peak_field: assert property ( // see R14
    @(posedge clock) disable iff (!rst_b)
    clkEn |=> ctrl_ff.peakCurrentLimit ==
      $past(limits_ff[CCL_PEAK_LSB +: 2]))
    else $error("Peak current field wrong.");
  chk_warn_lowest: assert property ( // see R13
    @(posedge clock) disable iff (!rst_b)
    clkEn && limits_ff[CCL_THERM_LSB +: 2] == 2'b00 |=>
      ctrl_ff.warnTempCelsius == CCL_WARN_TEMP_0)
    else $error("Lowest warning temperature wrong.");
  chk_warn_highest: assert property ( // see R13
    @(posedge clock) disable iff (!rst_b)
    clkEn && limits_ff[CCL_THERM_LSB +: 2] == 2'b11 |=>
      ctrl_ff.warnTempCelsius == CCL_WARN_TEMP_3)
    else $error("Highest warning temperature wrong.");

  // Fault sequence checks: a fault stops the stage, a restart is one pulse.
  chk_fault_stops: assert property ( // see R07
    @(posedge clock) disable iff (!rst_b)
    clkEn && faultS |=> !powerStageOn_ff && !powerUpStart_ff)
    else $error("Stage kept running during a fault.");
  chk_restart_pulse: assert property ( // see R08
    @(posedge clock) disable iff (!rst_b)
    clkEn && state_ff == CCL_SHUTDOWN && restartEn && !faultS |=>
      powerUpStart_ff && !powerStageOn_ff)
    else $error("Restart did not begin a power-up.");
  chk_pulse_single: assert property ( // see R08
    @(posedge clock) disable iff (!rst_b)
    clkEn && powerUpStart_ff |=> !powerUpStart_ff)
    else $error("Power-up start pulse too long.");
  chk_restart_keeps: assert property ( // see R08
    @(posedge clock) disable iff (!rst_b)
    clkEn && state_ff == CCL_RESTART && !regWrite.wrEn |=>
      $stable(modeCtrl_ff) && $stable(limits_ff))
    else $error("Registers changed by a restart.");

  // Clock-enable check: registers, state and read data hold while the enable is low.
  chk_frozen_state: assert property (
    @(posedge clock) disable iff (!rst_b)
    !clkEn |=> $stable(modeCtrl_ff) && $stable(limits_ff) &&
      $stable(state_ff) && $stable(readData_ff))
    else $error("State changed while the clock enable was low.");

endmodule : ccl_regs
`default_nettype wire

// >>> ccl_host.sv
// Host model that issues register writes to the converter control bank.
`timescale 1ns/100ps
`default_nettype none
module ccl_host (
  // Clock.
  input wire logic clock,
  // Write request towards the bank.
  output var ccl_pkg::ccl_write_t regWrite
);
  import ccl_pkg::*;

  // The request is idle from time zero.
  initial begin
    regWrite = '0;
  end

  // One byte write; the strobe stands for one edge, then fields are scrambled.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regWrite <= '{wrEn: 1'b1, addr: a, data: d};
    @(posedge clock);
    regWrite <= '{wrEn: 1'b0, addr: ~a, data: ~d};
  endtask : wr
endmodule : ccl_host
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the converter control register bank.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import ccl_pkg::*;
  typedef struct packed {
    logic [7:0] data;
    logic mode;
    logic ramp;
    logic [7:0] expRead;
    logic expForced;
    logic [1:0] expSleep;
  } ccl_row_t;
  // Mode control writes with mode and ramp inputs and expected outputs.
  localparam ccl_row_t ROWS [8] = '{
    '{8'hFF, 1'b1, 1'b0, 8'hF1, 1'b1, 2'b10},
    '{8'h40, 1'b1, 1'b0, 8'h40, 1'b1, 2'b01},
    '{8'h40, 1'b0, 1'b0, 8'h40, 1'b0, 2'b01},
    '{8'h80, 1'b0, 1'b0, 8'h80, 1'b1, 2'b01},
    '{8'h80, 1'b1, 1'b0, 8'h80, 1'b0, 2'b01},
    '{8'h30, 1'b1, 1'b1, 8'h30, 1'b1, 2'b10},
    '{8'hC0, 1'b1, 1'b1, 8'hC0, 1'b0, 2'b01},
    '{8'h0E, 1'b0, 1'b0, 8'h00, 1'b0, 2'b01}};
  localparam logic [7:0] TEMPS [4] = '{8'h53, 8'h5E, 8'h69, 8'h74};
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic clkEn = 1'b1;
  logic [7:0] readAddr = 8'h00;
  logic enablePin = 1'b0;
  logic voltageSelectPin = 1'b0;
  logic modeSignal = 1'b0;
  logic ramp = 1'b0;
  logic thermalShutdown = 1'b0;
  logic outputShortFault = 1'b0;
  logic seen;
  ccl_write_t regWrite;
  ccl_ctrl_t ctrl;
  logic [7:0] readData;
  logic powerStageOn;
  logic powerUpStart;
  int badCount = 0;
  int samplesChecked = 0;

  // Clock generator.
  always #20 clock = ~clock;

  ccl_host host (.clock(clock), .regWrite(regWrite));

  ccl_regs dut (.clock(clock), .rst_b(rst_b), .clkEn(clkEn),
    .regWrite(regWrite), .readAddr(readAddr), .readData_ff(readData),
    .enablePin(enablePin), .voltageSelectPin(voltageSelectPin),
    .modeSignal(modeSignal), .dynamicVoltageRamp(ramp),
    .thermalShutdown(thermalShutdown), .outputShortFault(outputShortFault),
    .ctrl_ff(ctrl), .powerStageOn_ff(powerStageOn),
    .powerUpStart_ff(powerUpStart));

  // Compares one value and reports a mismatch.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Reads one register and compares it.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    readAddr <= a;
    repeat (2) @(posedge clock);
    #1 chk(readData, exp);
  endtask : rd

  // Lets synchronisers and control registers follow.
  task automatic settle;
    repeat (5) @(posedge clock);
    #1;
  endtask : settle

  // Prints the verdict and ends the run.
  task automatic end_of_test;
    if (badCount == 0 && samplesChecked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  // Main sequence.
  initial begin
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    rd(8'h14, 8'h00);
    rd(8'h16, 8'h02);
    host.wr(8'h15, 8'hFF);
    rd(8'h15, 8'h00);
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      modeSignal <= ROWS[i].mode;
      ramp <= ROWS[i].ramp;
      host.wr(8'h14, ROWS[i].data);
      settle();
      chk(8'(ctrl.forcedPulseMode), 8'(ROWS[i].expForced));
      chk({6'h0, ctrl.fullSleep, ctrl.lowQuiescentMode},
          {6'h0, ROWS[i].expSleep});
      chk(8'(ctrl.selectPinGateEnable), 8'(ROWS[i].expRead[0]));
      rd(8'h14, ROWS[i].expRead);
    end
    // Enable high, or a gated select high, keeps the core awake.
    @(posedge clock);
    enablePin <= 1'b1;
    settle();
    chk({6'h0, ctrl.fullSleep, ctrl.lowQuiescentMode}, 8'h00);
    @(posedge clock);
    enablePin <= 1'b0;
    voltageSelectPin <= 1'b1;
    settle();
    chk({6'h0, ctrl.fullSleep, ctrl.lowQuiescentMode}, 8'h01);
    host.wr(8'h14, 8'h01);
    settle();
    chk({6'h0, ctrl.fullSleep, ctrl.lowQuiescentMode}, 8'h00);
    // A write made while the clock enable is low is not taken.
    @(posedge clock);
    voltageSelectPin <= 1'b0;
    clkEn <= 1'b0;
    host.wr(8'h14, 8'hF1);
    @(posedge clock);
    clkEn <= 1'b1;
    rd(8'h14, 8'h01);
    for (int i = 0; i < 4; i++) begin
      host.wr(8'h16, {2'(i), 2'(i), 4'h0});
      settle();
      chk(ctrl.warnTempCelsius, TEMPS[i]);
      chk(8'(ctrl.thermalWarningThreshold), 8'(i));
      chk(8'(ctrl.peakCurrentLimit), 8'(i));
      rd(8'h16, {2'(i), 2'(i), 4'h0});
    end
    // Soft reset right after programming both registers.
    host.wr(8'h14, 8'hF1);
    host.wr(8'h16, 8'h04);
    rd(8'h14, 8'h00);
    rd(8'h16, 8'h02);
    // Fault with restart disabled: the stage stays off.
    host.wr(8'h16, 8'h00);
    @(posedge clock);
    thermalShutdown <= 1'b1;
    settle();
    @(posedge clock);
    thermalShutdown <= 1'b0;
    repeat (12) @(posedge clock);
    #1 chk(8'(powerStageOn), 8'h00);
    // Second reset in mid-run, then a fault with restart enabled.
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    rd(8'h16, 8'h02);
    host.wr(8'h16, 8'hF1);
    host.wr(8'h14, 8'h41);
    @(posedge clock);
    outputShortFault <= 1'b1;
    settle();
    chk(8'(powerStageOn), 8'h00);
    @(posedge clock);
    outputShortFault <= 1'b0;
    seen = 1'b0;
    repeat (30) begin
      @(posedge clock);
      #1;
      if (powerUpStart === 1'b1) begin
        seen = 1'b1;
      end
    end
    chk(8'(seen), 8'h01);
    chk(8'(powerStageOn), 8'h01);
    rd(8'h16, 8'hF1);
    rd(8'h14, 8'h41);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
